/* File: src/eec_pkg.sv */
// Constants, register map and types for the exception-entry control block.
package eec_pkg;
    // Bit numbers are little-endian positions: big-endian bit n sits at 31-n.
    localparam int unsigned EE_POS = 15;
    localparam int unsigned ME_POS = 12;
    localparam int unsigned IP_POS = 6;
    localparam int unsigned RI_POS = 1;
    localparam int unsigned LE_POS = 0;
    localparam int unsigned ILE_POS = 16;
    localparam int unsigned FETCH_POS = 30;
    localparam logic [31:0] BASE_LOW = 32'h0000_0000;
    localparam logic [31:0] BASE_HIGH = 32'hFFF0_0000;
    localparam logic [31:0] OFS_RESET = 32'h0000_0100;
    localparam logic [31:0] OFS_MCHECK = 32'h0000_0200;
    localparam logic [31:0] OFS_EXTINT = 32'h0000_0500;
    localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_SET = 32'h2800_000F;
    localparam logic [31:0] UPPER_MASK = 32'h0000_FFFF;
    // Register byte offsets on APB.
    localparam logic [7:0] A_STATE = 8'h00;
    localparam logic [7:0] A_SPC = 8'h04;
    localparam logic [7:0] A_SMS = 8'h08;
    localparam logic [7:0] A_AFC = 8'h0C;
    localparam logic [7:0] A_FDA = 8'h10;
    localparam logic [7:0] A_DBG = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_FPEC = 8'h1C;
    localparam logic [7:0] A_TRC = 8'h20;
    localparam logic [7:0] A_LB1 = 8'h24;
    localparam logic [7:0] A_LB2 = 8'h28;
    localparam logic [7:0] A_CNTA = 8'h2C;
    localparam logic [7:0] A_CNTB = 8'h30;
    localparam logic [7:0] A_DPC = 8'h34;
    localparam logic [7:0] A_DPM = 8'h38;
    localparam logic [7:0] A_CCS = 8'h3C;
    localparam logic [7:0] A_CAP = 8'h40;
    localparam logic [7:0] A_CDP = 8'h44;
    localparam int unsigned N_REGS = 18;
    // Debug enable register bits.
    localparam int unsigned CHSTP_POS = 0;
    localparam int unsigned MCDBG_POS = 1;
    localparam int unsigned FREEZE_CYCLES = 2;
    typedef enum logic [1:0] {MC_HANDLER, MC_CHECKSTOP, MC_DEBUG} eec_mc_action_t;
endpackage

/* File: src/eec_core.sv */
// Exception-entry control: reset, machine check and external interrupt entry.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module eec_core (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic core_reset_n,
    input wire logic reset_cfg_high,
    input wire logic debug_mode_cfg,
    input wire logic ibus_error,
    input wire logic lbus_error,
    input wire logic [31:0] fault_instr_addr,
    input wire logic [31:0] fault_data_addr,
    input wire logic [31:0] fault_instr_word,
    input wire logic fault_x_form,
    input wire logic fault_recoverable,
    input wire logic irq_n,
    input wire logic higher_pending,
    input wire logic retire_done,
    input wire logic [31:0] next_instr_addr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic checkstop,
    output logic debug_entry,
    output logic retire_request
);
    // =====================================================================
    // Input synchronisers and register storage.
    logic [1:0] irq_sync_q;
    logic [1:0] rst_sync_q;
    logic [31:0] regs_q [eec_pkg::N_REGS];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic fetch_valid_q;
    logic [31:0] fetch_addr_q;
    logic checkstop_q;
    logic [1:0] freeze_q;
    logic debug_entry_q;
    logic retire_req_q;
    logic reset_pend_q;
    logic run;
    logic mc_event;
    logic ext_take;
    eec_pkg::eec_mc_action_t mc_act;

    function automatic int unsigned idx(input logic [7:0] a);
        return int'(a[7:2]);
    endfunction

    function automatic logic [31:0] vbase(input logic sel);
        return sel ? eec_pkg::BASE_HIGH : eec_pkg::BASE_LOW;
    endfunction

    // The interrupt request and core reset come from other logic that may not share our edge.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_sync_q <= 2'b11;
            rst_sync_q <= 2'b11;
        end else if (clk_en) begin
            irq_sync_q <= {irq_sync_q[0], irq_n};
            rst_sync_q <= {rst_sync_q[0], core_reset_n};
        end
    end

    logic [31:0] st;
    assign st = regs_q[idx(eec_pkg::A_STATE)];
    // Checkstop freezes machine check and interrupt entry; the bus slave and reset sequencing stay on the bus clock.
    assign run = clk_en && !checkstop_q && !reset_pend_q;
    assign mc_event = ibus_error || lbus_error;
    assign ext_take = !irq_sync_q[1] && st[eec_pkg::EE_POS] && !higher_pending
        && !mc_event && retire_done;

    always_comb begin
        logic [31:0] dbg;
        dbg = regs_q[idx(eec_pkg::A_DBG)];
        mc_act = eec_pkg::MC_HANDLER;
        if (st[eec_pkg::ME_POS]) begin
            if (debug_mode_cfg && dbg[eec_pkg::MCDBG_POS]) begin
                mc_act = eec_pkg::MC_DEBUG;
            end else begin
                mc_act = eec_pkg::MC_HANDLER;
            end
        end else if (debug_mode_cfg && dbg[eec_pkg::CHSTP_POS]) begin
            mc_act = eec_pkg::MC_DEBUG;
        end else begin
            mc_act = eec_pkg::MC_CHECKSTOP;
        end
    end

    // =====================================================================
    // Reset exception sequencing.
    // The reset exception is recognised without a clock on resetn but through the clocked synchroniser on core_reset_n; the first fetch follows on release.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reset_pend_q <= 1'b1;
        end else if (clk_en) begin
            if (!rst_sync_q[1]) begin
                reset_pend_q <= 1'b1;
            end else begin
                reset_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            checkstop_q <= 1'b0;
            freeze_q <= 2'b00;
        end else if (clk_en) begin
            if (reset_pend_q) begin
                checkstop_q <= 1'b0;
                freeze_q <= 2'b00;
            end else if (!checkstop_q && mc_event && mc_act == eec_pkg::MC_CHECKSTOP) begin
                checkstop_q <= 1'b1;
                freeze_q <= 2'(eec_pkg::FREEZE_CYCLES);
            end else if (freeze_q != 2'b00) begin
                freeze_q <= freeze_q - 2'b01;
            end
        end
    end

    // =====================================================================
    // Exception entry: fetch redirect, debug request and retire request.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fetch_valid_q <= 1'b0;
            fetch_addr_q <= eec_pkg::ZERO_RESET;
            debug_entry_q <= 1'b0;
            retire_req_q <= 1'b0;
        end else if (clk_en) begin
            fetch_valid_q <= 1'b0;
            debug_entry_q <= 1'b0;
            retire_req_q <= 1'b0;
            if (reset_pend_q && rst_sync_q[1]) begin
                fetch_valid_q <= 1'b1;
                fetch_addr_q <= vbase(reset_cfg_high) | eec_pkg::OFS_RESET;
            end else if (run && mc_event) begin
                if (mc_act == eec_pkg::MC_HANDLER) begin
                    fetch_valid_q <= 1'b1;
                    fetch_addr_q <= vbase(st[eec_pkg::IP_POS]) | eec_pkg::OFS_MCHECK;
                end else if (mc_act == eec_pkg::MC_DEBUG) begin
                    debug_entry_q <= 1'b1;
                end
            end else if (run && !irq_sync_q[1] && st[eec_pkg::EE_POS] && !higher_pending) begin
                if (ext_take) begin
                    fetch_valid_q <= 1'b1;
                    fetch_addr_q <= vbase(st[eec_pkg::IP_POS]) | eec_pkg::OFS_EXTINT;
                end else begin
                    retire_req_q <= 1'b1;
                end
            end
        end
    end

    // =====================================================================
    // Register file: APB writes, reset loads and exception context saves.
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (reset_pend_q && rst_sync_q[1]) begin
                // Only listed registers change; the rest keep their contents.
                regs_q[idx(eec_pkg::A_STATE)] <= (st & (32'h1 << eec_pkg::ME_POS))
                    | (32'(reset_cfg_high) << eec_pkg::IP_POS);
                regs_q[idx(eec_pkg::A_FPEC)] <= eec_pkg::ZERO_RESET;
                regs_q[idx(eec_pkg::A_TRC)] <= eec_pkg::ZERO_RESET;
                regs_q[idx(eec_pkg::A_LB1)] <= eec_pkg::ZERO_RESET;
                regs_q[idx(eec_pkg::A_LB2)] <= eec_pkg::ZERO_RESET;
                regs_q[idx(eec_pkg::A_CNTA)] <= regs_q[idx(eec_pkg::A_CNTA)]
                    & ~eec_pkg::UPPER_MASK;
                regs_q[idx(eec_pkg::A_CNTB)] <= regs_q[idx(eec_pkg::A_CNTB)]
                    & ~eec_pkg::UPPER_MASK;
                regs_q[idx(eec_pkg::A_DPC)] <= eec_pkg::ZERO_RESET;
                regs_q[idx(eec_pkg::A_DPM)] <= regs_q[idx(eec_pkg::A_DPM)] | eec_pkg::MASK_SET;
                regs_q[idx(eec_pkg::A_CCS)] <= eec_pkg::ZERO_RESET;
            end else if (run && mc_event && mc_act == eec_pkg::MC_HANDLER) begin
                regs_q[idx(eec_pkg::A_SPC)] <= fault_instr_addr;
                regs_q[idx(eec_pkg::A_SMS)] <= (st & eec_pkg::UPPER_MASK)
                    & ~(32'h1 << eec_pkg::RI_POS)
                    | (32'(fault_recoverable) << eec_pkg::RI_POS)
                    | (32'(ibus_error) << eec_pkg::FETCH_POS);
                regs_q[idx(eec_pkg::A_STATE)] <= (st & (32'h1 << eec_pkg::IP_POS))
                    | (32'(st[eec_pkg::ILE_POS]) << eec_pkg::LE_POS);
                if (lbus_error && !ibus_error) begin
                    regs_q[idx(eec_pkg::A_FDA)] <= fault_data_addr;
                    regs_q[idx(eec_pkg::A_AFC)] <= {15'h0000,
                        fault_x_form ? fault_instr_word[2:1] : 2'b00,
                        fault_x_form ? fault_instr_word[6] : fault_instr_word[26],
                        4'h0, fault_instr_word[25:16]};
                end
            end else if (run && !mc_event && ext_take) begin
                regs_q[idx(eec_pkg::A_SPC)] <= next_instr_addr;
                regs_q[idx(eec_pkg::A_SMS)] <= st & eec_pkg::UPPER_MASK;
                regs_q[idx(eec_pkg::A_STATE)] <= (st & ((32'h1 << eec_pkg::IP_POS)
                    | (32'h1 << eec_pkg::ME_POS)))
                    | (32'(st[eec_pkg::ILE_POS]) << eec_pkg::LE_POS);
            end else if (psel && penable && pwrite && idx(paddr) < eec_pkg::N_REGS
                && paddr != eec_pkg::A_STAT) begin
                regs_q[idx(paddr)] <= pwdata;
            end
        end
    end

    // =====================================================================
    // APB slave: one wait-free access phase; unmapped addresses return an error.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= eec_pkg::ZERO_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (clk_en) begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && idx(paddr) >= eec_pkg::N_REGS;
            if (psel && !penable) begin
                if (paddr == eec_pkg::A_STAT) begin
                    prdata_q <= {29'h0, retire_req_q, debug_entry_q, checkstop_q};
                end else if (idx(paddr) < eec_pkg::N_REGS) begin
                    prdata_q <= regs_q[idx(paddr)];
                end else begin
                    prdata_q <= eec_pkg::ZERO_RESET;
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fetch_valid = fetch_valid_q;
    assign fetch_addr = fetch_addr_q;
    assign checkstop = checkstop_q;
    assign debug_entry = debug_entry_q;
    assign retire_request = retire_req_q;

    // =====================================================================
    // Checks.
    // Machine check handler entry and the reset register load share these two antecedents.
    logic mc_handle;
    logic reset_load;
    assign mc_handle = run && mc_event && mc_act == eec_pkg::MC_HANDLER;
    assign reset_load = clk_en && reset_pend_q && rst_sync_q[1];

    chk_checkstop_sticky: assert property (@(posedge clock) disable iff (!resetn)
        checkstop_q && clk_en && !reset_pend_q |=> checkstop_q)
        else $error("checkstop dropped without reset");

    chk_mc_vector: assert property (@(posedge clock) disable iff (!resetn)
        run && mc_event && mc_act == eec_pkg::MC_HANDLER |=>
        fetch_valid_q && fetch_addr_q == (vbase($past(st[eec_pkg::IP_POS])) | 32'h200))
        else $error("machine check vector wrong");

    chk_ext_vector: assert property (@(posedge clock) disable iff (!resetn)
        run && !mc_event && ext_take |=>
        fetch_valid_q && fetch_addr_q[11:0] == 12'h500)
        else $error("external interrupt vector wrong");

    chk_ee_cleared: assert property (@(posedge clock) disable iff (!resetn)
        run && (ext_take || (mc_event && mc_act == eec_pkg::MC_HANDLER)) |=>
        !st[eec_pkg::EE_POS])
        else $error("enable bit not cleared on entry");

    chk_ext_blocked: assert property (@(posedge clock) disable iff (!resetn)
        !st[eec_pkg::EE_POS] && !mc_event && !reset_pend_q |=> !fetch_valid_q)
        else $error("interrupt taken while disabled");

    chk_me_cleared: assert property (@(posedge clock) disable iff (!resetn)
        run && mc_event && mc_act == eec_pkg::MC_HANDLER |=> !st[eec_pkg::ME_POS])
        else $error("check enable not cleared");

    chk_debug_entry: assert property (@(posedge clock) disable iff (!resetn)
        run && mc_event && mc_act == eec_pkg::MC_DEBUG |=> debug_entry_q && !fetch_valid_q)
        else $error("debug entry missing");

    chk_reset_fetch: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reset_pend_q && rst_sync_q[1] |=> fetch_valid_q && fetch_addr_q[11:0] == 12'h100)
        else $error("reset vector wrong");

    chk_checkstop_entry: assert property (@(posedge clock) disable iff (!resetn)
        run && mc_event && mc_act == eec_pkg::MC_CHECKSTOP
        |=> checkstop_q)
        else $error("checkstop not entered");

    chk_checkstop_quiet: assert property (@(posedge clock) disable iff (!resetn)
        checkstop_q
        |-> !fetch_valid_q && !debug_entry_q)
        else $error("activity in checkstop");

    chk_mc_spc: assert property (@(posedge clock) disable iff (!resetn)
        mc_handle
        |=> regs_q[idx(eec_pkg::A_SPC)] == $past(fault_instr_addr))
        else $error("machine check address wrong");

    chk_mc_fetch_flag: assert property (@(posedge clock) disable iff (!resetn)
        mc_handle
        |=> regs_q[idx(eec_pkg::A_SMS)][eec_pkg::FETCH_POS] == $past(ibus_error))
        else $error("fetch flag wrong");

    chk_mc_sms_clear: assert property (@(posedge clock) disable iff (!resetn)
        mc_handle
        |=> regs_q[idx(eec_pkg::A_SMS)][31] == 1'b0
        && regs_q[idx(eec_pkg::A_SMS)][29:16] == 14'h0000)
        else $error("saved state not cleared");

    chk_mc_recover: assert property (@(posedge clock) disable iff (!resetn)
        mc_handle
        |=> regs_q[idx(eec_pkg::A_SMS)][eec_pkg::RI_POS] == $past(fault_recoverable))
        else $error("recoverable flag wrong");

    chk_mc_fda: assert property (@(posedge clock) disable iff (!resetn)
        mc_handle && lbus_error && !ibus_error
        |=> regs_q[idx(eec_pkg::A_FDA)] == $past(fault_data_addr))
        else $error("fault data address wrong");

    chk_mc_byte_order: assert property (@(posedge clock) disable iff (!resetn)
        mc_handle
        |=> st[eec_pkg::LE_POS] == $past(st[eec_pkg::ILE_POS]))
        else $error("byte order not loaded");

    chk_ext_spc: assert property (@(posedge clock) disable iff (!resetn)
        run && ext_take
        |=> regs_q[idx(eec_pkg::A_SPC)] == $past(next_instr_addr))
        else $error("interrupt return address wrong");

    chk_ext_sms: assert property (@(posedge clock) disable iff (!resetn)
        run && ext_take
        |=> regs_q[idx(eec_pkg::A_SMS)] == ($past(st) & eec_pkg::UPPER_MASK))
        else $error("interrupt saved state wrong");

    chk_ext_me_kept: assert property (@(posedge clock) disable iff (!resetn)
        run && ext_take
        |=> st[eec_pkg::ME_POS] == $past(st[eec_pkg::ME_POS]))
        else $error("check enable changed");

    chk_ext_retire: assert property (@(posedge clock) disable iff (!resetn)
        run && !mc_event && !irq_sync_q[1] && st[eec_pkg::EE_POS] && !higher_pending
        && !retire_done |=> retire_req_q && !fetch_valid_q)
        else $error("interrupt taken before retire");

    chk_reset_base: assert property (@(posedge clock) disable iff (!resetn)
        reset_load
        |=> st[eec_pkg::IP_POS] == $past(reset_cfg_high))
        else $error("base select not loaded");

    chk_reset_zero: assert property (@(posedge clock) disable iff (!resetn)
        reset_load
        |=> regs_q[idx(eec_pkg::A_DPC)] == eec_pkg::ZERO_RESET
        && regs_q[idx(eec_pkg::A_CCS)] == eec_pkg::ZERO_RESET)
        else $error("reset registers not cleared");

    chk_reset_mask: assert property (@(posedge clock) disable iff (!resetn)
        reset_load
        |=> (regs_q[idx(eec_pkg::A_DPM)] & eec_pkg::MASK_SET) == eec_pkg::MASK_SET)
        else $error("mask bits not set");

    chk_reset_hold: assert property (@(posedge clock) disable iff (!resetn)
        reset_pend_q && !rst_sync_q[1]
        |=> !fetch_valid_q)
        else $error("fetch during reset");

    chk_reset_pend: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && !rst_sync_q[1]
        |=> reset_pend_q)
        else $error("reset request missed");

    cov_mcheck: cover property (@(posedge clock) run && mc_event);
    cov_checkstop: cover property (@(posedge clock) $rose(checkstop_q));
    cov_extint: cover property (@(posedge clock) run && ext_take);
    cov_debug: cover property (@(posedge clock) run && mc_event && mc_act == eec_pkg::MC_DEBUG);
    cov_reset: cover property (@(posedge clock) reset_load);
endmodule

/* File: tb/eec_far_side.sv */
// Far-side model: system interface and interrupt controller driving the core request lines.
`timescale 1ns/1ps
module eec_far_side (
    input wire logic clock,
    output logic core_reset_n,
    output logic reset_cfg_high,
    output logic debug_mode_cfg,
    output logic ibus_error,
    output logic lbus_error,
    output logic [31:0] fault_instr_addr,
    output logic [31:0] fault_data_addr,
    output logic [31:0] fault_instr_word,
    output logic fault_x_form,
    output logic fault_recoverable,
    output logic irq_n
);
    initial begin
        {core_reset_n, reset_cfg_high, debug_mode_cfg, ibus_error, lbus_error} = 5'b00000;
        {fault_instr_addr, fault_data_addr, fault_instr_word} = {3{32'h5A5A_A5A5}};
        {fault_x_form, fault_recoverable, irq_n} = 3'b001;
    end
    task automatic reset_pulse(input logic cfg, input logic dbg);
        @(posedge clock);
        {core_reset_n, reset_cfg_high, debug_mode_cfg} <= {1'b0, cfg, dbg};
        repeat (6) @(posedge clock);
        core_reset_n <= 1'b1;
    endtask
    // Fault details are only good beside the error pulse; afterwards the addresses and instruction word are
    // inverted so that a core which samples them late picks up wrong values.
    task automatic bus_error(input logic fetch, input logic [31:0] ia, input logic [31:0] da);
        @(posedge clock);
        {ibus_error, lbus_error} <= {fetch, !fetch};
        {fault_instr_addr, fault_data_addr} <= {ia, da};
        {fault_instr_word, fault_x_form, fault_recoverable} <= {32'h7C85_3A2E, 2'b11};
        @(posedge clock);
        {ibus_error, lbus_error} <= 2'b00;
        {fault_instr_addr, fault_data_addr} <= ~{ia, da};
        fault_instr_word <= ~32'h7C85_3A2E;
    endtask
    task automatic irq(input logic level);
        @(posedge clock);
        irq_n <= !level;
    endtask
endmodule

/* File: tb/test_eec_core.sv */
// Self-checking testbench for the exception-entry control block.
`timescale 1ns/1ps
module test_eec_core;
    localparam logic [31:0] ONES = 32'hFFFF_FFFF;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic higher_pending = 1'b0;
    logic retire_done = 1'b1;
    logic [31:0] next_instr_addr = 32'h0000_0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, fetch_addr, fault_instr_addr, fault_data_addr, fault_instr_word;
    logic [31:0] last_fetch, rd;
    logic pready, pslverr, fetch_valid, checkstop, debug_entry, retire_request, err;
    logic core_reset_n, reset_cfg_high, debug_mode_cfg, ibus_error, lbus_error;
    logic fault_x_form, fault_recoverable, irq_n, me, dm, cs, mc, take, dbgx;
    int err_count = 0;
    int checks = 0;
    int fetch_cnt = 0;
    int dbg_cnt = 0;
    int ret_cnt = 0;
    int cyc = 0;
    int f0, d0, r0;
    logic [7:0] zreg [8] = '{eec_pkg::A_FPEC, eec_pkg::A_TRC, eec_pkg::A_LB1, eec_pkg::A_LB2,
        eec_pkg::A_CNTA, eec_pkg::A_CNTB, eec_pkg::A_DPC, eec_pkg::A_CCS};
    logic [31:0] zmsk [8] = '{ONES, ONES, ONES, ONES, eec_pkg::UPPER_MASK,
        eec_pkg::UPPER_MASK, ONES, ONES};

    always #2 clock = ~clock;

    eec_far_side far (.clock, .core_reset_n, .reset_cfg_high, .debug_mode_cfg, .ibus_error,
        .lbus_error, .fault_instr_addr, .fault_data_addr, .fault_instr_word, .fault_x_form,
        .fault_recoverable, .irq_n);
    eec_core dut (.clock, .resetn, .clk_en(1'b1), .core_reset_n, .reset_cfg_high,
        .debug_mode_cfg, .ibus_error, .lbus_error, .fault_instr_addr, .fault_data_addr,
        .fault_instr_word, .fault_x_form, .fault_recoverable, .irq_n, .higher_pending,
        .retire_done, .next_instr_addr, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fetch_valid, .fetch_addr, .checkstop, .debug_entry,
        .retire_request);

    // ==========
    // Monitors: fetch_valid and debug_entry are single-cycle pulses and retire_request stays high while waiting, so they are counted at every edge.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (fetch_valid === 1'b1) begin
            fetch_cnt <= fetch_cnt + 1;
            last_fetch <= fetch_addr;
        end
        if (debug_entry === 1'b1) begin
            dbg_cnt <= dbg_cnt + 1;
        end
        if (retire_request === 1'b1) begin
            ret_cnt <= ret_cnt + 1;
        end
        if (cyc == 30000) begin
            err_count++;
            print_verdict();
        end
    end

    // ==========
    // Access tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdat, output logic e);
        int k;
        k = 0;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            err_count++;
        end
        rdat = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
        input string what);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(what, rd & m, exp);
    endtask
    task automatic wait_fetch(input logic [31:0] exp, input string what);
        int n0;
        int k;
        n0 = fetch_cnt;
        k = 0;
        while (fetch_cnt == n0 && k < 40) begin
            @(posedge clock);
            k++;
        end
        check(what, (fetch_cnt != n0) ? last_fetch : 32'hxxxx_xxxx, exp);
    endtask
    task automatic quiet(input string what);
        f0 = fetch_cnt;
        repeat (12) @(posedge clock);
        check(what, 32'(fetch_cnt - f0), 32'h0000_0000);
    endtask
    task automatic full_reset(input logic cfg, input logic dbg);
        resetn <= 1'b0;
        far.reset_pulse(cfg, dbg);
        resetn <= 1'b1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========
    // Main sequence
    initial begin
        full_reset(1'b0, 1'b0);
        wait_fetch(32'h0000_0100, "reset_vector");
        // Check enable keeps its unknown power-on value over reset, so it is masked here.
        rchk(eec_pkg::A_STATE, 32'hFFFF_EFFF, 32'h0000_0000, "state_reset");
        for (int i = 0; i < 8; i++) begin
            rchk(zreg[i], zmsk[i], 32'h0000_0000, "reset_zero");
        end
        rchk(eec_pkg::A_DPM, eec_pkg::MASK_SET, eec_pkg::MASK_SET, "mask_set");
        apb(1'b0, 8'h48, 32'h0000_0000, rd, err);
        check("unmapped_err", {31'h0000_0000, err}, 32'h0000_0001);
        wr(eec_pkg::A_STAT, ONES);
        rchk(eec_pkg::A_STAT, ONES, 32'h0000_0000, "status_ro");
        wr(eec_pkg::A_STATE, 32'h0000_9000);
        wr(eec_pkg::A_FDA, 32'h1234_5678);
        wr(eec_pkg::A_FPEC, 32'h0000_00FF);
        far.reset_pulse(1'b1, 1'b0);
        wait_fetch(32'hFFF0_0100, "reset_high");
        rchk(eec_pkg::A_STATE, ONES, 32'h0000_1040, "state_cfg");
        rchk(eec_pkg::A_FDA, ONES, 32'h1234_5678, "kept");
        rchk(eec_pkg::A_FPEC, ONES, 32'h0000_0000, "fpec_zero");
        wr(eec_pkg::A_STATE, 32'h0001_D0C2);
        far.bus_error(1'b1, 32'h0000_3A40, 32'h0000_0000);
        wait_fetch(32'hFFF0_0200, "mc_vector");
        rchk(eec_pkg::A_SPC, ONES, 32'h0000_3A40, "mc_spc");
        rchk(eec_pkg::A_SMS, ONES, 32'h4000_D0C2, "mc_sms_fetch");
        rchk(eec_pkg::A_STATE, ONES, 32'h0000_0041, "mc_state");
        wr(eec_pkg::A_STATE, 32'h0000_9042);
        far.bus_error(1'b0, 32'h0000_3A44, 32'h0000_8C14);
        wait_fetch(32'hFFF0_0200, "mc_data");
        rchk(eec_pkg::A_FDA, ONES, 32'h0000_8C14, "mc_fda");
        rchk(eec_pkg::A_AFC, ONES, 32'h0001_8085, "mc_afc");
        rchk(eec_pkg::A_SMS, ONES, 32'h0000_9042, "mc_sms_data");
        rchk(eec_pkg::A_STATE, ONES, 32'h0000_0040, "mc_state_d");
        wr(eec_pkg::A_STATE, 32'h0001_1043);
        next_instr_addr <= 32'h0000_2468;
        far.irq(1'b1);
        quiet("ext_masked");
        higher_pending <= 1'b1;
        wr(eec_pkg::A_STATE, 32'h0001_9043);
        quiet("ext_higher");
        r0 = ret_cnt;
        {higher_pending, retire_done} <= 2'b00;
        quiet("ext_retire");
        check("retire_req", 32'(ret_cnt != r0), 32'h0000_0001);
        retire_done <= 1'b1;
        wait_fetch(32'hFFF0_0500, "ext_vector");
        rchk(eec_pkg::A_SPC, ONES, 32'h0000_2468, "ext_spc");
        rchk(eec_pkg::A_SMS, ONES, 32'h0000_9043, "ext_sms");
        rchk(eec_pkg::A_STATE, ONES, 32'h0000_1041, "ext_state");
        quiet("ext_once");
        far.irq(1'b0);
        // Checkstop can only be left by reset, so every action case starts from a fresh one.
        for (int i = 0; i < 16; i++) begin
            {mc, cs, dm, me} = 4'(i);
            full_reset(1'b0, dm);
            wait_fetch(32'h0000_0100, "loop_reset");
            wr(eec_pkg::A_DBG, (32'(cs) << eec_pkg::CHSTP_POS) | (32'(mc) << eec_pkg::MCDBG_POS));
            wr(eec_pkg::A_STATE, {19'h0_0000, me, 12'h000});
            {f0, d0} = {fetch_cnt, dbg_cnt};
            take = me && (!dm || !mc);
            dbgx = dm && (me ? mc : cs);
            far.bus_error(1'b0, 32'h0000_0400, 32'h0000_0800);
            repeat (3) @(posedge clock);
            check("mc_taken", 32'(fetch_cnt - f0), 32'(take));
            check("mc_debug", 32'(dbg_cnt - d0), 32'(dbgx));
            check("mc_stop", {31'h0000_0000, checkstop}, 32'(!take && !dbgx));
        end
        print_verdict();
    end
endmodule
